// [hw/tpsc_level_quant.v]
// Purpose: Registered quantizer of an 8-bit level against four steps.
// Assumes: Thresholds ascend; a threshold of 256 is never reached.
// Notes: Output counts the thresholds at or below the level.
`timescale 1ns/1ps
module tpsc_level_quant #(
    parameter [8:0] T0 = 9'h040,
    parameter [8:0] T1 = 9'h080,
    parameter [8:0] T2 = 9'h0C0,
    parameter [8:0] T3 = 9'h100
) (
    input wire ref_clk,
    input wire reset_n,
    input wire [7:0] level,
    output reg [2:0] code
);
    wire [8:0] wide = {1'b0, level};
    reg [2:0] next_code;

    always @* begin
        next_code = 3'h0;
        if (wide >= T3) begin
            next_code = 3'h4;
        end else if (wide >= T2) begin
            next_code = 3'h3;
        end else if (wide >= T1) begin
            next_code = 3'h2;
        end else if (wide >= T0) begin
            next_code = 3'h1;
        end
    end

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            code <= 3'h0;
        end else begin
            code <= next_code;
        end
    end
endmodule // tpsc_level_quant

// [hw/tpsc_map.vh]
// Purpose: Constants for the tuner synthesizer serial control block.
// Assumes: Analog levels arrive as 8-bit fractions of supply (256 = VCC).
// Notes: Included by bare name; definitions only.
`ifndef TPSC_MAP_VH
`define TPSC_MAP_VH

// ------------------------------------------------------------------
// Slave address and byte layout
// ------------------------------------------------------------------
`define TPSC_ADDR_FIXED 5'h18
`define TPSC_CTRL_FLAG_BIT 7
`define TPSC_CB_PUMP_BIT 6
`define TPSC_CB_TEST_HI 5
`define TPSC_CB_TEST_LO 3
`define TPSC_CB_RATIO_FIRST_BIT 2
`define TPSC_CB_RATIO_SECOND_BIT 1
`define TPSC_CB_TUNE_DIS_BIT 0
`define TPSC_BB_FM_BIT 3
`define TPSC_BB_UHF_BIT 2
`define TPSC_BB_VHFH_BIT 1
`define TPSC_BB_VHFL_BIT 0

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define TPSC_RST_TEST 3'h1
`define TPSC_RST_PUMP 1'b1
`define TPSC_RST_RATIO_FIRST 1'b0
`define TPSC_RST_RATIO_SECOND 1'b1
`define TPSC_RST_TUNE_DIS 1'b1
`define TPSC_RST_PORTS 4'h0
`define TPSC_RST_DIVIDE 15'h0000
`define TPSC_RST_POR 1'b1

// ------------------------------------------------------------------
// Test modes and reference divider ratios
// ------------------------------------------------------------------
`define TPSC_TEST_REF_OUT 3'h4
`define TPSC_TEST_DIV_OUT 3'h5
`define TPSC_TEST_SINK 3'h6
`define TPSC_TEST_SOURCE 3'h7
`define TPSC_RATIO_80 8'h50
`define TPSC_RATIO_128 8'h80
`define TPSC_RATIO_64 8'h40

// ------------------------------------------------------------------
// Level thresholds, in 1/256 of supply
// ------------------------------------------------------------------
`define TPSC_AS_T0 9'h026
`define TPSC_AS_T1 9'h05A
`define TPSC_AS_T2 9'h0C0
`define TPSC_AS_T3 9'h100
`define TPSC_ADC_T0 9'h026
`define TPSC_ADC_T1 9'h04D
`define TPSC_ADC_T2 9'h073
`define TPSC_ADC_T3 9'h09A
`endif

// [hw/tpsc_serial_ctrl.v]
// Purpose: Serial control and status logic of a tuner synthesizer.
// Assumes: Bus pins and levels are synchronous to ref_clk and slow.
`timescale 1ns/1ps
`include "tpsc_map.vh"
module tpsc_serial_ctrl (
    input wire ref_clk,
    input wire reset_n,
    input wire busModeI2c,
    input wire sclIn,
    input wire sdaIn,
    output reg sdaOut,
    output reg sdaOe,
    input wire [7:0] addrSelLevel,
    input wire addrSelOpen,
    input wire [7:0] adcLevel,
    input wire loopLocked,
    output reg [1:0] moduleAddrBits,
    output reg [14:0] divideCountBits,
    output reg pumpCurrentSel,
    output reg pumpOff,
    output reg pumpSink,
    output reg pumpSource,
    output reg lockPinRefOut,
    output reg lockPinDivOut,
    output reg adcUsable,
    output reg [7:0] refDivRatio,
    output reg tuningOutputEnable,
    output reg [3:0] bandPortBits,
    output reg uhfPathOn,
    output reg vhfPathOn,
    output reg vhfHighBand
);
    // ------------------------------------------------------------------
    // States and helpers
    // ------------------------------------------------------------------
    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_ADDR = 7'h02;
    localparam [6:0] ST_ACK_ADDR = 7'h04;
    localparam [6:0] ST_WRITE = 7'h08;
    localparam [6:0] ST_ACK_WR = 7'h10;
    localparam [6:0] ST_READ = 7'h20;
    localparam [6:0] ST_ACK_RD = 7'h40;
    localparam [2:0] EXP_FIRST = 3'h1;
    localparam [2:0] EXP_LOWER = 3'h2;
    localparam [2:0] EXP_BAND = 3'h4;

    // True for the test modes that route a frequency to the lock pin.
    function routesFreq;
        input [2:0] t;
        begin
            routesFreq = (t == `TPSC_TEST_REF_OUT) ||
                (t == `TPSC_TEST_DIV_OUT);
        end
    endfunction

    reg [6:0] state;
    reg [2:0] byteKind;
    reg gotByte;
    reg sclPrev;
    reg sdaPrev;
    reg [2:0] bitCnt;
    reg [7:0] rxShift;
    reg [7:0] txShift;
    reg readDir;
    reg masterNack;
    reg [6:0] upperHold;
    reg [2:0] testSelectBits;
    reg ratioSelectFirst;
    reg ratioSelectSecond;
    reg tuningOutputDisable;
    reg por;
    wire [2:0] asCode;
    wire [2:0] adcRaw;

    wire sclRise = sclIn && !sclPrev;
    wire sclFall = !sclIn && sclPrev;
    wire startCond = sclIn && sclPrev && sdaPrev && !sdaIn;
    wire stopCond = sclIn && sclPrev && !sdaPrev && sdaIn;
    wire [7:0] rxByte = {rxShift[6:0], sdaIn};
    wire adcOk = busModeI2c && !routesFreq(testSelectBits);
    wire readyFlag = !((testSelectBits == `TPSC_RST_TEST) &&
        loopLocked);
    // Status assembled fresh; sampled only when a byte starts.
    wire [7:0] statusNow = {por, loopLocked, readyFlag, 2'b11,
        adcOk ? adcRaw : 3'h0};

    // ------------------------------------------------------------------
    // Level quantizers
    // ------------------------------------------------------------------
    tpsc_level_quant #(
        .T0(`TPSC_AS_T0), .T1(`TPSC_AS_T1),
        .T2(`TPSC_AS_T2), .T3(`TPSC_AS_T3)
    ) u_as_quant (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .level(addrSelLevel),
        .code(asCode)
    );

    tpsc_level_quant #(
        .T0(`TPSC_ADC_T0), .T1(`TPSC_ADC_T1),
        .T2(`TPSC_ADC_T2), .T3(`TPSC_ADC_T3)
    ) u_adc_quant (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .level(adcLevel),
        .code(adcRaw)
    );

    // ------------------------------------------------------------------
    // Bus engine
    // ------------------------------------------------------------------
    // Everything moves on clock edges seen through ref_clk, so the
    // serial clock must stay well below a quarter of ref_clk.
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            byteKind <= EXP_FIRST;
            gotByte <= 1'b0;
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
            bitCnt <= 3'h0;
            rxShift <= 8'h00;
            txShift <= 8'h00;
            readDir <= 1'b0;
            masterNack <= 1'b0;
            upperHold <= 7'h00;
            sdaOut <= 1'b0;
            sdaOe <= 1'b0;
            por <= `TPSC_RST_POR;
            divideCountBits <= `TPSC_RST_DIVIDE;
            pumpCurrentSel <= `TPSC_RST_PUMP;
            testSelectBits <= `TPSC_RST_TEST;
            ratioSelectFirst <= `TPSC_RST_RATIO_FIRST;
            ratioSelectSecond <= `TPSC_RST_RATIO_SECOND;
            tuningOutputDisable <= `TPSC_RST_TUNE_DIS;
            bandPortBits <= `TPSC_RST_PORTS;
        end else begin
            sclPrev <= sclIn;
            sdaPrev <= sdaIn;
            if (!busModeI2c || stopCond) begin
                state <= ST_IDLE;
                sdaOe <= 1'b0;
            end else if (startCond) begin
                state <= ST_ADDR;
                byteKind <= EXP_FIRST;
                bitCnt <= 3'h0;
                gotByte <= 1'b0;
                sdaOe <= 1'b0;
            end else begin
                case (state)
                ST_ADDR, ST_WRITE: begin
                    // The fall that ends a start carries no byte, so only
                    // a fall after the eighth rise may close one.
                    if (sclRise) begin
                        rxShift <= rxByte;
                        bitCnt <= bitCnt + 3'h1;
                        gotByte <= (bitCnt == 3'h7);
                    end else if (sclFall && gotByte &&
                        state == ST_ADDR) begin
                        gotByte <= 1'b0;
                        if (rxShift[7:1] ==
                            {`TPSC_ADDR_FIXED, moduleAddrBits}) begin
                            readDir <= rxShift[0];
                            state <= ST_ACK_ADDR;
                            sdaOe <= 1'b1;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end else if (sclFall && gotByte) begin
                        gotByte <= 1'b0;
                        // Loads happen just after the eighth clock.
                        state <= ST_ACK_WR;
                        sdaOe <= 1'b1;
                        case (byteKind)
                        EXP_FIRST: begin
                            if (rxShift[`TPSC_CTRL_FLAG_BIT]) begin
                                pumpCurrentSel <=
                                    rxShift[`TPSC_CB_PUMP_BIT];
                                testSelectBits <= rxShift[
                                    `TPSC_CB_TEST_HI:`TPSC_CB_TEST_LO];
                                ratioSelectFirst <=
                                    rxShift[`TPSC_CB_RATIO_FIRST_BIT];
                                ratioSelectSecond <=
                                    rxShift[`TPSC_CB_RATIO_SECOND_BIT];
                                tuningOutputDisable <=
                                    rxShift[`TPSC_CB_TUNE_DIS_BIT];
                                byteKind <= EXP_BAND;
                            end else begin
                                upperHold <= rxShift[6:0];
                                byteKind <= EXP_LOWER;
                            end
                        end
                        EXP_LOWER: begin
                            divideCountBits <=
                                {upperHold, rxShift};
                            byteKind <= EXP_FIRST;
                        end
                        EXP_BAND: begin
                            bandPortBits <= rxShift[3:0];
                            byteKind <= EXP_FIRST;
                        end
                        default: begin
                            byteKind <= EXP_FIRST;
                        end
                        endcase
                    end
                end
                ST_ACK_ADDR, ST_ACK_WR: begin
                    if (sclFall && readDir && state == ST_ACK_ADDR) begin
                        state <= ST_READ;
                        sdaOe <= !statusNow[7];
                        txShift <= {statusNow[6:0], 1'b0};
                        bitCnt <= 3'h1;
                    end else if (sclFall) begin
                        state <= ST_WRITE;
                        sdaOe <= 1'b0;
                        bitCnt <= 3'h0;
                    end
                end
                ST_READ: begin
                    if (sclFall && bitCnt == 3'h0) begin
                        state <= ST_ACK_RD;
                        sdaOe <= 1'b0;
                    end else if (sclFall) begin
                        sdaOe <= !txShift[7];
                        txShift <= {txShift[6:0], 1'b0};
                        bitCnt <= bitCnt + 3'h1;
                    end
                end
                ST_ACK_RD: begin
                    if (sclRise) begin
                        masterNack <= sdaIn;
                    end else if (sclFall && masterNack) begin
                        state <= ST_IDLE;
                        sdaOe <= 1'b0;
                        por <= 1'b0;
                    end else if (sclFall) begin
                        state <= ST_READ;
                        sdaOe <= !statusNow[7];
                        txShift <= {statusNow[6:0], 1'b0};
                        bitCnt <= 3'h1;
                    end
                end
                default: begin
                    sdaOe <= 1'b0;
                end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Registered decodes for the analog side
    // ------------------------------------------------------------------
    // Open pin wins over the level so a floating input cannot dither.
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            moduleAddrBits <= 2'h0;
            pumpOff <= 1'b0;
            pumpSink <= 1'b0;
            pumpSource <= 1'b0;
            lockPinRefOut <= 1'b0;
            lockPinDivOut <= 1'b0;
            adcUsable <= 1'b0;
            refDivRatio <= `TPSC_RATIO_128;
            tuningOutputEnable <= 1'b0;
            uhfPathOn <= 1'b0;
            vhfPathOn <= 1'b1;
            vhfHighBand <= 1'b0;
        end else begin
            moduleAddrBits <= addrSelOpen ? 2'h1 : asCode[1:0];
            pumpOff <= (testSelectBits[2:1] == 2'b01);
            pumpSink <= (testSelectBits == `TPSC_TEST_SINK);
            pumpSource <= (testSelectBits == `TPSC_TEST_SOURCE);
            lockPinRefOut <= (testSelectBits == `TPSC_TEST_REF_OUT);
            lockPinDivOut <= (testSelectBits == `TPSC_TEST_DIV_OUT);
            adcUsable <= adcOk;
            if (!ratioSelectSecond) begin
                refDivRatio <= `TPSC_RATIO_80;
            end else if (ratioSelectFirst) begin
                refDivRatio <= `TPSC_RATIO_64;
            end else begin
                refDivRatio <= `TPSC_RATIO_128;
            end
            tuningOutputEnable <= !tuningOutputDisable;
            uhfPathOn <= bandPortBits[`TPSC_BB_UHF_BIT];
            vhfPathOn <= !bandPortBits[`TPSC_BB_UHF_BIT];
            vhfHighBand <= bandPortBits[`TPSC_BB_VHFH_BIT];
        end
    end
    // The pump current level itself is pumpCurrentSel: 0 low, 1 high.
endmodule // tpsc_serial_ctrl

// [sim/testbench.sv]
// Purpose: Self-checking bench for the serial control block.
// Assumes: Address select sits mid supply, giving module bits 10.
// Notes: Bus traffic comes from the master model's tasks.
`timescale 1ns/1ps
module testbench;
    localparam int LIMIT = 60000;
    localparam logic [7:0] ADW = 8'hC4;
    localparam logic [7:0] ADR = 8'hC5;
    logic refClk, resetN, busModeI2c, sclIn, sdaRel, sdaOut, sdaOe;
    logic addrSelOpen, loopLocked, pumpCurrentSel, pumpOff, pumpSink;
    logic pumpSource, lockPinRefOut, lockPinDivOut, adcUsable;
    logic tuningOutputEnable, uhfPathOn, vhfPathOn, vhfHighBand, ack;
    logic [7:0] addrSelLevel, adcLevel, refDivRatio;
    logic [1:0] moduleAddrBits;
    logic [14:0] divideCountBits;
    logic [3:0] bandPortBits;
    int badCount, checkCount, cycles;
    logic [7:0] lvl [5] = '{8'h10, 8'h40, 8'h80, 8'hF0, 8'h00};
    logic [1:0] exa [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1};
    logic [7:0] adl [5] = '{8'h10, 8'h30, 8'h60, 8'h80, 8'hD0};
    // Open drain: only a low from either side reaches the wire.
    wire sdaWire = sdaRel & ~(sdaOe & ~sdaOut);

    tpsc_serial_ctrl i_tpsc_serial_ctrl (.ref_clk(refClk), .reset_n(resetN),
        .busModeI2c(busModeI2c), .sclIn(sclIn), .sdaIn(sdaWire),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelLevel(addrSelLevel),
        .addrSelOpen(addrSelOpen), .adcLevel(adcLevel),
        .loopLocked(loopLocked), .moduleAddrBits(moduleAddrBits),
        .divideCountBits(divideCountBits), .pumpCurrentSel(pumpCurrentSel),
        .pumpOff(pumpOff), .pumpSink(pumpSink), .pumpSource(pumpSource),
        .lockPinRefOut(lockPinRefOut), .lockPinDivOut(lockPinDivOut),
        .adcUsable(adcUsable), .refDivRatio(refDivRatio),
        .tuningOutputEnable(tuningOutputEnable), .bandPortBits(bandPortBits),
        .uhfPathOn(uhfPathOn), .vhfPathOn(vhfPathOn),
        .vhfHighBand(vhfHighBand));
    tpsc_i2c_master m (.ref_clk(refClk), .sdaWire(sdaWire), .scl(sclIn),
        .sdaRel(sdaRel));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] s, input logic [15:0] e);
        checkCount++;
        if (s !== e) begin
            badCount++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic report_and_stop();
        if (badCount == 0 && checkCount > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Reset is also pulsed mid-run so that defaults are seen after writes.
    task automatic reset_dut();
        resetN = 1'b0;
        repeat (16) @(negedge refClk);
        resetN = 1'b1;
        m.tick(4);
        check(divideCountBits, 16'h0000);
        check(refDivRatio, 16'h0080);
        check({pumpCurrentSel, pumpOff, pumpSink, pumpSource, lockPinRefOut,
            lockPinDivOut, tuningOutputEnable, uhfPathOn, vhfPathOn,
            vhfHighBand, bandPortBits}, 16'h2020);
    endtask
    task automatic wr(input logic [7:0] a, input int n, input logic [31:0] d);
        logic k;
        m.start();
        m.wrb(a, k);
        check(k, 1'b1);
        for (int i = 0; i < n; i++) begin
            m.wrb(d[31 - 8 * i -: 8], k);
            check(k, 1'b1);
        end
        m.stop();
        m.tick(4);
    endtask
    task automatic rd(input logic [7:0] e, input int n);
        logic [7:0] v;
        logic k;
        m.start();
        m.wrb(ADR, k);
        check(k, 1'b1);
        for (int i = 1; i <= n; i++) begin
            m.rdb(i < n, v);
            check(v, e);
        end
        m.tick(4);
        check(sdaOe, 1'b0);
        m.stop();
    endtask
    task automatic refused(input logic [7:0] a);
        m.start();
        m.wrb(a, ack);
        check(ack, 1'b0);
        m.stop();
    endtask

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        refClk = 1'b0;
        forever #12.5 refClk = ~refClk;
    end
    always @(posedge refClk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            badCount++;
            report_and_stop();
        end
    end
    initial begin
        badCount = 0;
        checkCount = 0;
        busModeI2c = 1'b1;
        addrSelOpen = 1'b0;
        addrSelLevel = 8'h80;
        adcLevel = 8'h80;
        loopLocked = 1'b1;
        reset_dut();
        for (int i = 0; i < 5; i++) begin
            addrSelOpen = (i == 4);
            addrSelLevel = lvl[i];
            m.tick(4);
            check(moduleAddrBits, exa[i]);
        end
        addrSelOpen = 1'b0;
        addrSelLevel = 8'h80;
        m.tick(4);
        rd(8'hDB, 2);
        rd(8'h5B, 1);
        refused(8'hC6);
        busModeI2c = 1'b0;
        m.tick(4);
        check(adcUsable, 1'b0);
        refused(ADR);
        busModeI2c = 1'b1;
        for (int i = 0; i < 5; i++) begin
            adcLevel = adl[i];
            loopLocked = (i != 0);
            rd({1'b0, i != 0, i == 0, 2'b11, i[2:0]}, 1);
        end
        wr(ADW, 4, 32'h2A5C_A605);
        check(divideCountBits, 16'h2A5C);
        check({pumpCurrentSel, lockPinRefOut, adcUsable, tuningOutputEnable},
            16'h0005);
        check(refDivRatio, 16'h0040);
        check({bandPortBits, uhfPathOn, vhfPathOn, vhfHighBand},
            16'h002C);
        rd(8'h78, 1);
        wr(ADW, 1, 32'h1100_0000);
        check(divideCountBits, 16'h2A5C);
        wr(ADW, 2, 32'h4001_0000);
        check(divideCountBits, 16'h4001);
        for (int t = 0; t < 8; t++) begin
            wr(ADW, 1, {2'b11, t[2:0], 3'h1, 24'h0});
            check({pumpOff, pumpSink, pumpSource, lockPinRefOut,
                lockPinDivOut, tuningOutputEnable}, {t[2:1] == 2'b01,
                t == 6, t == 7, t == 4, t == 5, 1'b0});
            check(refDivRatio, 16'h0050);
        end
        wr(ADW, 2, 32'hCB0A_0000);
        check(refDivRatio, 16'h0080);
        check({bandPortBits, uhfPathOn, vhfPathOn, vhfHighBand},
            16'h0053);
        // The level drops mid-byte; the captured code must not follow it.
        fork
            rd(8'h5C, 1);
            begin
                m.tick(150);
                adcLevel = 8'h10;
            end
        join
        adcLevel = 8'hD0;
        reset_dut();
        rd(8'hDC, 1);
        report_and_stop();
    end
endmodule // testbench

// [sim/tpsc_i2c_master.sv]
// Purpose: Behavioural two-wire bus master facing the control block.
// Assumes: The wire has a pull-up; sdaRel high releases it.
// Notes: Each bit's clock phase lasts six reference clocks.
`timescale 1ns/1ps
module tpsc_i2c_master (
    input wire ref_clk,
    input wire sdaWire,
    output logic scl,
    output logic sdaRel
);
    initial begin
        scl = 1'b1;
        sdaRel = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic start();
        sdaRel = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(6);
        sdaRel = 1'b0;
        tick(6);
        scl = 1'b0;
    endtask
    // Stop waits out the low phase so the slave sees a clean release.
    task automatic stop();
        tick(3);
        sdaRel = 1'b0;
        tick(3);
        scl = 1'b1;
        tick(6);
        sdaRel = 1'b1;
        tick(6);
    endtask
    task automatic xfer(input logic b, output logic r);
        tick(3);
        sdaRel = b;
        tick(3);
        scl = 1'b1;
        tick(3);
        r = sdaWire;
        tick(3);
        scl = 1'b0;
    endtask
    task automatic wrb(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xfer(d[i], r);
        xfer(1'b1, r);
        ack = !r;
    endtask
    task automatic rdb(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
        xfer(!more, r);
    endtask
endmodule // tpsc_i2c_master

// [sim/tpsc_serial_ctrl_asserts.sv]
// Purpose: Concurrent checks on the ports of the serial control block.
// Assumes: Bus phases last at least four reference clocks.
// Notes: Bound into every instance of the block.
`timescale 1ns/1ps
module tpsc_serial_ctrl_asserts (
    input wire ref_clk,
    input wire reset_n,
    input wire busModeI2c,
    input wire sclIn,
    input wire sdaOe,
    input wire [7:0] addrSelLevel,
    input wire addrSelOpen,
    input wire [1:0] moduleAddrBits,
    input wire [14:0] divideCountBits,
    input wire pumpCurrentSel,
    input wire pumpOff,
    input wire pumpSink,
    input wire pumpSource,
    input wire lockPinRefOut,
    input wire lockPinDivOut,
    input wire adcUsable,
    input wire [7:0] refDivRatio,
    input wire [3:0] bandPortBits,
    input wire uhfPathOn,
    input wire vhfPathOn
);
    // ------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sda_low_change_a: assert property ($changed(sdaOe) |-> !sclIn)
        else $error("data line changed while clock high");
    test_onehot_a: assert property ($onehot0({pumpOff, pumpSink,
        pumpSource, lockPinRefOut, lockPinDivOut}))
        else $error("more than one test decode active");
    adc_route_a: assert property ((lockPinRefOut || lockPinDivOut) [*2]
        |-> !adcUsable) else $error("adc usable while routing a frequency");
    mode_idle_a: assert property (!busModeI2c [*3]
        |-> !sdaOe && !adcUsable) else $error("active outside bus mode");
    ratio_legal_a: assert property (refDivRatio inside {8'h50, 8'h80,
        8'h40}) else $error("illegal reference ratio");
    band_decode_a: assert property ($stable(bandPortBits) [*2]
        |-> uhfPathOn == bandPortBits[2] && vhfPathOn == !bandPortBits[2])
        else $error("band path decode wrong");
    addr_open_a: assert property (addrSelOpen [*3]
        |-> moduleAddrBits == 2'b01) else $error("open pin address wrong");
    addr_band_a: assert property ((!addrSelOpen && $stable(addrSelLevel)
        && (addrSelLevel <= 8'h19 || addrSelLevel >= 8'hE6)) [*3]
        |-> moduleAddrBits == {2{addrSelLevel[7]}})
        else $error("edge band address wrong");
    reg_load_a: assert property ($changed({divideCountBits, pumpCurrentSel,
        bandPortBits}) |-> !sclIn) else $error("register load off clock low");
    cover property ($rose(sdaOe));
    cover property (lockPinDivOut);
    cover property ($rose(uhfPathOn));
endmodule // tpsc_serial_ctrl_asserts

bind tpsc_serial_ctrl tpsc_serial_ctrl_asserts i_chk (.ref_clk(ref_clk),
    .reset_n(reset_n), .busModeI2c(busModeI2c), .sclIn(sclIn),
    .sdaOe(sdaOe), .addrSelLevel(addrSelLevel), .addrSelOpen(addrSelOpen),
    .moduleAddrBits(moduleAddrBits), .divideCountBits(divideCountBits),
    .pumpCurrentSel(pumpCurrentSel), .pumpOff(pumpOff), .pumpSink(pumpSink),
    .pumpSource(pumpSource), .lockPinRefOut(lockPinRefOut),
    .lockPinDivOut(lockPinDivOut), .adcUsable(adcUsable),
    .refDivRatio(refDivRatio), .bandPortBits(bandPortBits),
    .uhfPathOn(uhfPathOn), .vhfPathOn(vhfPathOn));
